// ==== verilog/rcm_pkg.sv ====
// constants and register map of the radio channel measurement block
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package rcm_pkg;
	// register byte offsets
	localparam logic [7:0] RCM_OFS_IDLE_EN = 8'h00;
	localparam logic [7:0] RCM_OFS_COMB = 8'h04;
	localparam logic [7:0] RCM_OFS_AVGP_LO = 8'h08;
	localparam logic [7:0] RCM_OFS_AVGP_HI = 8'h0C;
	localparam logic [7:0] RCM_OFS_THR = 8'h10;
	localparam logic [7:0] RCM_OFS_ACT_RES = 8'h20;
	localparam logic [7:0] RCM_OFS_IDLE_RES = 8'h40;
	// reset values
	localparam logic [31:0] RCM_RST_IDLE_EN = 32'h0000_0000;
	localparam logic [31:0] RCM_RST_COMB = 32'h3333_3333;
	localparam logic [31:0] RCM_RST_AVGP = 32'h0404_0404;
	localparam logic [31:0] RCM_RST_THR = 32'h2F23_170B;
	// combination codes, 2 bits in each nibble of the comb register
	localparam logic [1:0] RCM_COMB_FR = 2'h0; // (i),(viii),(ix),(iii)
	localparam logic [1:0] RCM_COMB_HR = 2'h1; // (ii)
	localparam logic [1:0] RCM_COMB_SD = 2'h2; // (v),(vii)
	localparam logic [1:0] RCM_COMB_NONE = 2'h3; // (x)
	localparam int RCM_COMB_DATA_BIT = 2; // subset uses data silence count
	// burst kinds
	localparam logic [1:0] RCM_KIND_TCH = 2'h0;
	localparam logic [1:0] RCM_KIND_SID = 2'h1;
	localparam logic [1:0] RCM_KIND_SACCH = 2'h2;
	localparam logic [1:0] RCM_KIND_SDCCH = 2'h3;
	// frame counts per reporting period
	localparam logic [7:0] RCM_SID_SPEECH = 8'h08;
	localparam logic [7:0] RCM_SID_DATA = 8'h0A;
	localparam logic [7:0] RCM_FULL_FR = 8'h64; // 96 + 4
	localparam logic [7:0] RCM_FULL_HR = 8'h34; // 48 + 4
	localparam logic [7:0] RCM_FULL_SD = 8'h0C; // 8 + 4
	// level coding: rxlev = 3/4 * log2 scale - offset, clamped
	localparam logic [7:0] RCM_LVL_OFS = 8'h10;
	localparam logic [5:0] RCM_LVL_MAX = 6'h3F;
	// ber 0.2 % is one error in 500 bits; bands double up to 12.8 %
	localparam logic [15:0] RCM_BER_DEN = 16'h01F4;
	localparam int RCM_QUAL_STEPS = 7;
	localparam int RCM_BANDS = 5;
endpackage : rcm_pkg

// ==== verilog/rcm_top.sv ====
// radio channel measurement: active averaging, speech index, idle interference
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rcm_top import rcm_pkg::*; #(
	parameter int NTS = 8,
	parameter int HIST = 32
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// active burst samples from the receiver
	input wire logic burst_valid,
	input wire logic [2:0] burst_ts,
	input wire logic [1:0] burst_kind,
	input wire logic [15:0] burst_rms,
	input wire logic [7:0] burst_err,
	input wire logic [7:0] burst_bits,
	input wire logic burst_dtx,
	input wire logic burst_frame_err,
	// reporting period boundary per timeslot from frame timing
	input wire logic period_end,
	input wire logic [2:0] period_ts,
	// idle measurement period results
	input wire logic idle_valid,
	input wire logic [2:0] idle_ts,
	input wire logic idle_half,
	input wire logic [15:0] idle_rms,
	// active channel report
	output logic act_rep_valid,
	output logic [2:0] act_rep_ts,
	output logic [5:0] act_rxlev_full,
	output logic [5:0] act_rxlev_sub,
	output logic [2:0] act_qual_full,
	output logic [2:0] act_qual_sub,
	output logic [5:0] speech_quality_index,
	// idle channel report
	output logic idle_rep_valid,
	output logic [2:0] idle_rep_ts,
	output logic [5:0] idle_rep_level,
	output logic [2:0] idle_rep_band
);
	// -----------------------------------------------------------------------
	// helper functions
	// -----------------------------------------------------------------------
	// log2 with 3 fraction bits, scaled to dB and clamped to the level code
	function automatic logic [5:0] lvl_code(input logic [15:0] rms);
		logic [6:0] lq;
		logic [8:0] db;
		logic [15:0] sh;
		lq = 7'h00;
		sh = rms;
		for (int i = 0; i < 16; i++) begin
			if (rms[i]) begin
				lq = {i[3:0], 3'h0};
				sh = rms << (15 - i);
			end
		end
		lq = lq | {4'h0, sh[14:12]};
		db = ({2'h0, lq} * 9'h003) >> 2;
		if (db <= {1'b0, RCM_LVL_OFS})
			lvl_code = 6'h00;
		else if (db - {1'b0, RCM_LVL_OFS} > {3'h0, RCM_LVL_MAX})
			lvl_code = RCM_LVL_MAX;
		else
			lvl_code = 6'(db - {1'b0, RCM_LVL_OFS});
	endfunction : lvl_code

	// restoring divider, quotient saturates to six bits
	function automatic logic [5:0] avg6(input logic [15:0] num, input logic [7:0] den);
		logic [15:0] q;
		logic [16:0] r;
		q = 16'h0000;
		r = 17'h00000;
		for (int i = 15; i >= 0; i--) begin
			r = {r[15:0], num[i]};
			if (r >= {9'h000, den} && den != 8'h00) begin
				r = r - {9'h000, den};
				q[i] = 1'b1;
			end
		end
		avg6 = (q > 16'h003F) ? 6'h3F : q[5:0];
	endfunction : avg6

	// ber to quality class 0..7, thresholds 0.2 % doubling to 12.8 %
	function automatic logic [2:0] qual(input logic [15:0] err, input logic [15:0] bits);
		logic [31:0] lhs;
		qual = 3'h7;
		lhs = {16'h0000, err} * {16'h0000, RCM_BER_DEN};
		for (int k = RCM_QUAL_STEPS - 1; k >= 0; k--) begin
			if (lhs < ({16'h0000, bits} << k))
				qual = 3'(k);
		end
		if (bits == 16'h0000)
			qual = 3'h0;
	endfunction : qual

	// -----------------------------------------------------------------------
	// configuration registers
	// -----------------------------------------------------------------------
	logic [31:0] idle_en_r, comb_r, avgp_lo_r, avgp_hi_r, thr_r;
	logic wr_stb;
	assign wr_stb = psel & penable & pwrite & ~pready;

	// software writes, taken on the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_en_r <= RCM_RST_IDLE_EN;
			comb_r <= RCM_RST_COMB;
			avgp_lo_r <= RCM_RST_AVGP;
			avgp_hi_r <= RCM_RST_AVGP;
			thr_r <= RCM_RST_THR;
		end else if (wr_stb) begin
			unique case (paddr)
				RCM_OFS_IDLE_EN: idle_en_r <= pwdata;
				RCM_OFS_COMB: comb_r <= pwdata;
				RCM_OFS_AVGP_LO: avgp_lo_r <= pwdata;
				RCM_OFS_AVGP_HI: avgp_hi_r <= pwdata;
				RCM_OFS_THR: thr_r <= pwdata;
				default: ;
			endcase
		end
	end

	// -----------------------------------------------------------------------
	// active channel accumulation, one set per timeslot
	// -----------------------------------------------------------------------
	logic [15:0] f_lvl[NTS], s_lvl[NTS], f_err[NTS], s_err[NTS], f_bit[NTS], s_bit[NTS];
	logic [15:0] q_err[NTS], q_bit[NTS];
	logic [7:0] f_cnt[NTS], s_cnt[NTS], sid_cnt[NTS], fer_cnt[NTS];
	logic [5:0] res_lf[NTS], res_ls[NTS], res_sqi[NTS], n_lf[NTS], n_ls[NTS], n_sqi[NTS];
	logic [2:0] res_qf[NTS], res_qs[NTS], n_qf[NTS], n_qs[NTS];
	logic [5:0] b_lvl;
	assign b_lvl = lvl_code(burst_rms);

	genvar g;
	generate
		for (g = 0; g < NTS; g++) begin : g_act
			logic [1:0] cmb;
			logic [7:0] sid_lim, full_lim;
			logic hit, clr, to_sub;
			logic [5:0] qf, qs, pen;
			assign cmb = comb_r[4*g +: 2];
			assign sid_lim = comb_r[4*g + RCM_COMB_DATA_BIT] ? RCM_SID_DATA : RCM_SID_SPEECH;
			assign full_lim = (cmb == RCM_COMB_HR) ? RCM_FULL_HR :
				(cmb == RCM_COMB_SD) ? RCM_FULL_SD : RCM_FULL_FR;
			// combination (x) never accumulates
			assign hit = burst_valid && burst_ts == 3'(g) && cmb != RCM_COMB_NONE && f_cnt[g] < full_lim;
			assign clr = period_end && period_ts == 3'(g);
			// SACCH frames and every frame of the SD combination always enter the subset; silence frames up to their count
			assign to_sub = burst_kind == RCM_KIND_SACCH || cmb == RCM_COMB_SD ||
				(burst_kind == RCM_KIND_SID && sid_cnt[g] < sid_lim);

			// accumulators restart at each period boundary of this timeslot
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					{f_lvl[g], f_err[g], f_bit[g], s_lvl[g], s_err[g], s_bit[g]} <= '0;
					{f_cnt[g], s_cnt[g], sid_cnt[g]} <= '0;
				end else if (clr) begin
					{f_lvl[g], f_err[g], f_bit[g], s_lvl[g], s_err[g], s_bit[g]} <= '0;
					{f_cnt[g], s_cnt[g], sid_cnt[g]} <= '0;
				end else if (hit) begin
					f_lvl[g] <= f_lvl[g] + {10'h000, b_lvl};
					f_err[g] <= f_err[g] + {8'h00, burst_err};
					f_bit[g] <= f_bit[g] + {8'h00, burst_bits};
					f_cnt[g] <= f_cnt[g] + 8'h01;
					if (burst_kind == RCM_KIND_SID)
						sid_cnt[g] <= sid_cnt[g] + 8'h01;
					if (to_sub) begin
						s_lvl[g] <= s_lvl[g] + {10'h000, b_lvl};
						s_err[g] <= s_err[g] + {8'h00, burst_err};
						s_bit[g] <= s_bit[g] + {8'h00, burst_bits};
						s_cnt[g] <= s_cnt[g] + 8'h01;
					end
				end
			end

			// speech index inputs, discontinuous frames skipped
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					{q_err[g], q_bit[g], fer_cnt[g]} <= '0;
				end else if (clr) begin
					{q_err[g], q_bit[g], fer_cnt[g]} <= '0;
				end else if (hit && !burst_dtx && burst_kind != RCM_KIND_SACCH) begin
					q_err[g] <= q_err[g] + {8'h00, burst_err};
					q_bit[g] <= q_bit[g] + {8'h00, burst_bits};
					if (burst_frame_err && fer_cnt[g] != 8'hFF)
						fer_cnt[g] <= fer_cnt[g] + 8'h01;
				end
			end

			// speech index: 63 less quality and frame error penalties
			assign qf = {3'h0, qual(q_err[g], q_bit[g])} * 6'h07;
			assign pen = (fer_cnt[g] > 8'h0F) ? 6'h20 : {1'b0, fer_cnt[g][3:0], 1'b0};
			assign qs = (qf + pen > 6'h3F || {1'b0, qf} + {1'b0, pen} > 7'h3F) ? 6'h3F : qf + pen;

			// period results from the running sums, taken at the boundary
			assign n_lf[g] = avg6(f_lvl[g], f_cnt[g]);
			assign n_ls[g] = avg6(s_lvl[g], s_cnt[g]);
			assign n_qf[g] = qual(f_err[g], f_bit[g]);
			assign n_qs[g] = qual(s_err[g], s_bit[g]);
			assign n_sqi[g] = 6'h3F - qs;

			// results frozen at the boundary, visible through the next period
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					{res_lf[g], res_ls[g], res_sqi[g], res_qf[g], res_qs[g]} <= '0;
				end else if (clr && cmb != RCM_COMB_NONE) begin
					res_lf[g] <= n_lf[g];
					res_ls[g] <= n_ls[g];
					res_qf[g] <= n_qf[g];
					res_qs[g] <= n_qs[g];
					res_sqi[g] <= n_sqi[g];
				end
			end
		end
	endgenerate

	// active report one cycle after the boundary, inside the new period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{act_rep_valid, act_rep_ts, act_rxlev_full, act_rxlev_sub, act_qual_full, act_qual_sub} <= '0;
			speech_quality_index <= 6'h00;
		end else begin
			act_rep_valid <= period_end && comb_r[4*period_ts +: 2] != RCM_COMB_NONE;
			if (period_end) begin
				act_rep_ts <= period_ts;
				act_rxlev_full <= n_lf[period_ts];
				act_rxlev_sub <= n_ls[period_ts];
				act_qual_full <= n_qf[period_ts];
				act_qual_sub <= n_qs[period_ts];
				speech_quality_index <= n_sqi[period_ts];
			end
		end
	end

	// -----------------------------------------------------------------------
	// idle channel sliding window
	// -----------------------------------------------------------------------
	logic [5:0] hist[NTS*HIST];
	logic [4:0] wptr[NTS];
	logic [5:0] nval[NTS];
	logic [1:0] seen[NTS];
	logic [10:0] isum[NTS];
	logic [5:0] iavg[NTS];
	logic [2:0] iband[NTS];
	logic ifirst[NTS];
	logic [5:0] i_lvl;
	logic [7:0] per_raw;
	logic [5:0] win;
	logic i_on;
	assign i_lvl = lvl_code(idle_rms);
	assign per_raw = idle_ts[2] ? avgp_hi_r[8*idle_ts[1:0] +: 8] : avgp_lo_r[8*idle_ts[1:0] +: 8];
	assign win = (per_raw == 8'h00) ? 6'h01 : (per_raw > 8'(HIST)) ? 6'(HIST) : per_raw[5:0];
	assign i_on = idle_en_r[{idle_half, idle_ts}];

	// new window state for the addressed timeslot
	logic [5:0] n_nxt;
	logic [10:0] sum_nxt;
	logic [5:0] avg_nxt;
	logic [2:0] band_nxt;
	logic emit_nxt;
	always_comb begin
		n_nxt = (nval[idle_ts] < win) ? nval[idle_ts] + 6'h01 : win;
		if (nval[idle_ts] < win)
			sum_nxt = isum[idle_ts] + {5'h00, i_lvl};
		else
			sum_nxt = isum[idle_ts] + {5'h00, i_lvl} - {5'h00, hist[{idle_ts, wptr[idle_ts]}]};
		avg_nxt = avg6({5'h00, sum_nxt}, {2'h0, n_nxt});
		band_nxt = 3'h0;
		for (int b = 0; b < RCM_BANDS - 1; b++) begin
			if (avg_nxt > thr_r[8*b +: 6])
				band_nxt = band_nxt + 3'h1;
		end
		emit_nxt = seen[idle_ts] != 2'h0 && (n_nxt == 6'h02 || n_nxt == win);
	end

	// window memory
	always_ff @(posedge pclk) begin
		if (idle_valid && i_on)
			hist[{idle_ts, wptr[idle_ts]}] <= i_lvl;
	end

	// window pointers, sums, band memory; switching off restarts the window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int t = 0; t < NTS; t++) begin
				{wptr[t], nval[t], seen[t], isum[t], iavg[t], iband[t]} <= '0;
				ifirst[t] <= 1'b1;
			end
		end else if (idle_valid && !i_on) begin
			{nval[idle_ts], wptr[idle_ts], seen[idle_ts], isum[idle_ts]} <= '0;
			ifirst[idle_ts] <= 1'b1;
		end else if (idle_valid) begin
			nval[idle_ts] <= n_nxt;
			isum[idle_ts] <= sum_nxt;
			wptr[idle_ts] <= ({1'b0, wptr[idle_ts]} + 6'h01 >= win) ? 5'h00 : wptr[idle_ts] + 5'h01;
			if (seen[idle_ts] != 2'h2)
				seen[idle_ts] <= seen[idle_ts] + 2'h1;
			if (emit_nxt) begin
				iavg[idle_ts] <= avg_nxt;
				iband[idle_ts] <= band_nxt;
				ifirst[idle_ts] <= 1'b0;
			end
		end
	end

	// idle report: first average, then only on a band change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{idle_rep_valid, idle_rep_ts, idle_rep_level, idle_rep_band} <= '0;
		end else begin
			idle_rep_valid <= idle_valid && i_on && emit_nxt &&
				(ifirst[idle_ts] || band_nxt != iband[idle_ts]);
			if (idle_valid && i_on && emit_nxt) begin
				idle_rep_ts <= idle_ts;
				idle_rep_level <= avg_nxt;
				idle_rep_band <= band_nxt;
			end
		end
	end

	// -----------------------------------------------------------------------
	// apb read path: one wait state, unmapped answers with an error
	// -----------------------------------------------------------------------
	logic [31:0] rd_nxt;
	logic err_nxt;
	always_comb begin
		rd_nxt = 32'h0000_0000;
		err_nxt = 1'b0;
		if (paddr[7:5] == RCM_OFS_ACT_RES[7:5] && paddr[1:0] == 2'h0)
			rd_nxt = {8'h00, res_sqi[paddr[4:2]], res_qs[paddr[4:2]], res_qf[paddr[4:2]],
				res_ls[paddr[4:2]], res_lf[paddr[4:2]]};
		else if (paddr[7:5] == RCM_OFS_IDLE_RES[7:5] && paddr[1:0] == 2'h0)
			rd_nxt = {22'h00_0000, ifirst[paddr[4:2]], iband[paddr[4:2]], iavg[paddr[4:2]]};
		else begin
			unique case (paddr)
				RCM_OFS_IDLE_EN: rd_nxt = idle_en_r;
				RCM_OFS_COMB: rd_nxt = comb_r;
				RCM_OFS_AVGP_LO: rd_nxt = avgp_lo_r;
				RCM_OFS_AVGP_HI: rd_nxt = avgp_hi_r;
				RCM_OFS_THR: rd_nxt = thr_r;
				default: err_nxt = 1'b1;
			endcase
		end
	end

	// answer registered, so every apb output comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{pready, pslverr, prdata} <= '0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & err_nxt;
			prdata <= (psel & penable & ~pready & ~pwrite) ? rd_nxt : 32'h0000_0000;
		end
	end
endmodule : rcm_top
`default_nettype wire

// ==== verification/rcm_top_props.sv ====
// assertion checker for the radio channel measurement block
`timescale 1ns/1ps
`default_nettype none
module rcm_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// period and idle inputs
	input wire logic period_end,
	input wire logic [2:0] period_ts,
	input wire logic idle_valid,
	input wire logic [2:0] idle_ts,
	// reports
	input wire logic act_rep_valid,
	input wire logic [2:0] act_rep_ts,
	input wire logic idle_rep_valid,
	input wire logic [2:0] idle_rep_ts,
	input wire logic [2:0] idle_rep_band
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// bus answer timing
	// ------------------------------------------------------------
	a_ready_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("pready not one wait state after access start");
	a_ready_has_cause: assert property (pready |-> $past(psel && penable) ##1 !pready)
		else $error("pready without access or longer than one cycle");
	a_slverr_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside the answer cycle");
	a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero outside the answer cycle");
	// ------------------------------------------------------------
	// report timing and content
	// ------------------------------------------------------------
	a_act_after_end: assert property (act_rep_valid |-> $past(period_end))
		else $error("active report without a closed period");
	a_act_ts_match: assert property (act_rep_valid |-> act_rep_ts == $past(period_ts))
		else $error("active report for the wrong timeslot");
	a_idle_after_meas: assert property (idle_rep_valid |-> $past(idle_valid) && idle_rep_ts == $past(idle_ts))
		else $error("idle report without a matching measurement");
	a_band_in_range: assert property (idle_rep_valid |-> idle_rep_band <= 3'h4)
		else $error("interference band out of range");
endmodule : rcm_checker
bind rcm_top rcm_checker rcm_checker_i (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata,
	.period_end, .period_ts, .idle_valid, .idle_ts, .act_rep_valid, .act_rep_ts, .idle_rep_valid,
	.idle_rep_ts, .idle_rep_band);
`default_nettype wire

// ==== verification/rcm_bsc_model.sv ====
// controller side model collecting measurement reports
`timescale 1ns/1ps
`default_nettype none
module rcm_bsc_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// active report
	input wire logic act_rep_valid,
	input wire logic [5:0] act_rxlev_full,
	input wire logic [5:0] act_rxlev_sub,
	input wire logic [2:0] act_qual_full,
	input wire logic [2:0] act_qual_sub,
	input wire logic [5:0] speech_quality_index,
	// idle report
	input wire logic idle_rep_valid,
	input wire logic [5:0] idle_rep_level,
	input wire logic [2:0] idle_rep_band,
	// collected results
	output logic [15:0] act_cnt,
	output logic [31:0] act_word,
	output logic [15:0] idle_cnt,
	output logic [8:0] idle_word
);
	// count and keep each active result message
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_cnt <= 16'h0000;
			act_word <= 32'h0000_0000;
		end else if (act_rep_valid) begin
			act_cnt <= act_cnt + 16'h0001;
			act_word <= {8'h00, speech_quality_index, act_qual_sub, act_qual_full, act_rxlev_sub, act_rxlev_full};
		end
	end
	// count and keep each idle interference message
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt <= 16'h0000;
			idle_word <= 9'h000;
		end else if (idle_rep_valid) begin
			idle_cnt <= idle_cnt + 16'h0001;
			idle_word <= {idle_rep_level, idle_rep_band};
		end
	end
endmodule : rcm_bsc_model
`default_nettype wire

// ==== verification/rcm_top_tb.sv ====
// self-checking testbench of the radio channel measurement block
`timescale 1ns/1ps
`default_nettype none
module rcm_top_tb import rcm_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, burst_valid, burst_dtx, burst_frame_err;
	logic period_end, idle_valid, idle_half, act_rep_valid, idle_rep_valid;
	logic [7:0] paddr, burst_err, burst_bits;
	logic [31:0] pwdata, prdata, act_word;
	logic [2:0] burst_ts, period_ts, idle_ts, act_rep_ts, act_qual_full, act_qual_sub, idle_rep_ts, idle_rep_band;
	logic [1:0] burst_kind;
	logic [15:0] burst_rms, idle_rms, act_cnt, idle_cnt;
	logic [5:0] act_rxlev_full, act_rxlev_sub, speech_quality_index, idle_rep_level;
	logic [8:0] idle_word;
	int errors, compares;
	// design and controller model
	rcm_top rcm_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
		.burst_valid, .burst_ts, .burst_kind, .burst_rms, .burst_err, .burst_bits, .burst_dtx, .burst_frame_err,
		.period_end, .period_ts, .idle_valid, .idle_ts, .idle_half, .idle_rms, .act_rep_valid, .act_rep_ts,
		.act_rxlev_full, .act_rxlev_sub, .act_qual_full, .act_qual_sub, .speech_quality_index,
		.idle_rep_valid, .idle_rep_ts, .idle_rep_level, .idle_rep_band);
	rcm_bsc_model rcm_bsc_model_i (.pclk, .presetn, .act_rep_valid, .act_rxlev_full, .act_rxlev_sub,
		.act_qual_full, .act_qual_sub, .speech_quality_index, .idle_rep_valid, .idle_rep_level,
		.idle_rep_band, .act_cnt, .act_word, .idle_cnt, .idle_word);
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic end_of_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) errors++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
		check("write error", 32'h0000_0000, {31'h0, er});
	endtask : wr
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0000_0000, rd, er);
		check(name, exp, rd);
		check("slave error", {31'h0, exp_err}, {31'h0, er});
	endtask : rd_chk
	// n bursts on one timeslot, one per cycle; dtx, frame error and error count optional
	task automatic burst(input logic [2:0] ts, input logic [1:0] kind, input logic [15:0] rms, input int n,
		input logic dtx = 1'b0, input logic ferr = 1'b0, input logic [7:0] err = 8'h08);
		repeat (n) begin
			@(posedge pclk);
			burst_valid <= 1'b1;
			burst_ts <= ts;
			burst_kind <= kind;
			burst_rms <= rms;
			burst_dtx <= dtx;
			burst_frame_err <= ferr;
			burst_err <= err;
		end
	endtask : burst
	task automatic close_period(input logic [2:0] ts);
		@(posedge pclk);
		burst_valid <= 1'b0;
		period_end <= 1'b1;
		period_ts <= ts;
		@(posedge pclk);
		period_end <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : close_period
	// one idle measurement on timeslot 4 and the report it should raise
	task automatic idle(input logic half, input logic [15:0] rms, input logic rep, input logic [5:0] lvl,
		input logic [2:0] band);
		logic [15:0] n0;
		n0 = idle_cnt;
		@(posedge pclk);
		idle_valid <= 1'b1;
		idle_ts <= 3'h4;
		idle_half <= half;
		idle_rms <= rms;
		@(posedge pclk);
		idle_valid <= 1'b0;
		repeat (3) @(posedge pclk);
		check("idle report count", 32'(n0) + 32'(rep), 32'(idle_cnt));
		if (rep) check("idle report", {23'h0, lvl, band}, {23'h0, idle_word});
	endtask : idle
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_registers();
		rd_chk("idle enable", RCM_OFS_IDLE_EN, RCM_RST_IDLE_EN, 1'b0);
		rd_chk("combination", RCM_OFS_COMB, RCM_RST_COMB, 1'b0);
		rd_chk("average low", RCM_OFS_AVGP_LO, RCM_RST_AVGP, 1'b0);
		rd_chk("average high", RCM_OFS_AVGP_HI, RCM_RST_AVGP, 1'b0);
		rd_chk("thresholds", RCM_OFS_THR, RCM_RST_THR, 1'b0);
		rd_chk("unmapped", 8'h14, 32'h0000_0000, 1'b1);
		wr(RCM_OFS_THR, 32'h3020_100A);
		rd_chk("thresholds written", RCM_OFS_THR, 32'h3020_100A, 1'b0);
		wr(RCM_OFS_THR, RCM_RST_THR);
	endtask : t_registers
	// full rate, half rate and control combinations; excess bursts at level 0 must be dropped
	task automatic t_active();
		logic [15:0] n0;
		logic [31:0] exp;
		exp = {8'h00, 6'h15, 3'h6, 3'h6, 6'h20, 6'h20};
		wr(RCM_OFS_COMB, 32'h3304_3210);
		for (int i = 0; i < 3; i++) begin
			burst(3'(i), RCM_KIND_SACCH, 16'h0100, 4);
			burst(3'(i), i == 2 ? RCM_KIND_SDCCH : RCM_KIND_TCH, 16'h0100, i == 0 ? 96 : (i == 1 ? 48 : 8));
			burst(3'(i), i == 2 ? RCM_KIND_SDCCH : RCM_KIND_TCH, 16'h0001, 10);
			n0 = act_cnt;
			close_period(3'(i));
			check("active report count", 32'(n0) + 32'd1, 32'(act_cnt));
			check("active report", exp, act_word);
			rd_chk("active result", RCM_OFS_ACT_RES + 8'(4 * i), exp, 1'b0);
		end
		n0 = act_cnt;
		close_period(3'h3);
		check("no report for unmeasured", 32'(n0), 32'(act_cnt));
		// ts4 full rate data, ts5 full rate speech: silence limit, dtx skip, frame error penalty
		for (int i = 4; i < 6; i++) begin
			burst(3'(i), RCM_KIND_SACCH, 16'h0100, 4);
			burst(3'(i), RCM_KIND_SID, 16'h0100, 8);
			burst(3'(i), RCM_KIND_SID, 16'h1000, 2);
			burst(3'(i), RCM_KIND_SID, 16'h0001, 2, i == 4, i == 5, i == 4 ? 8'h40 : 8'h08);
			close_period(3'(i));
			exp = (i == 4) ? {8'h00, 6'h15, 3'h6, 3'h7, 6'h23, 6'h1F} : {8'h00, 6'h11, 3'h6, 3'h6, 6'h20, 6'h1F};
			check("silence subset report", exp, act_word);
		end
	endtask : t_active
	// window of three on timeslot 4, levels 32 then 56 then 8
	task automatic t_idle();
		wr(RCM_OFS_AVGP_HI, 32'h0404_0403);
		wr(RCM_OFS_IDLE_EN, 32'h0000_0010);
		idle(1'b0, 16'h0100, 1'b0, 6'h00, 3'h0);
		idle(1'b0, 16'h0100, 1'b1, 6'h20, 3'h2);
		idle(1'b0, 16'h0100, 1'b0, 6'h00, 3'h0);
		idle(1'b0, 16'h1000, 1'b1, 6'h28, 3'h3);
		idle(1'b0, 16'h1000, 1'b1, 6'h30, 3'h4);
		idle(1'b0, 16'h1000, 1'b0, 6'h00, 3'h0);
		idle(1'b1, 16'h0010, 1'b0, 6'h00, 3'h0);
		idle(1'b0, 16'h0010, 1'b0, 6'h00, 3'h0);
		idle(1'b0, 16'h0010, 1'b1, 6'h08, 3'h0);
	endtask : t_idle
	// ------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		errors = 0;
		compares = 0;
		{presetn, psel, penable, pwrite, burst_valid, burst_dtx, burst_frame_err} = 7'h00;
		{period_end, idle_valid, idle_half} = 3'h0;
		{paddr, pwdata, burst_ts, period_ts, idle_ts, burst_kind, burst_rms, idle_rms} = '0;
		burst_err = 8'h08;
		burst_bits = 8'h64;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_registers();
		t_active();
		t_idle();
		end_of_test();
	end
	initial begin
		#500000;
		errors++;
		end_of_test();
	end
endmodule : rcm_top_tb
`default_nettype wire
